// ==== common/drsl_pkg.sv ====
/*
 * package for the device-ready status logic: register offsets, field positions,
 * reset values, interrupt bits and packed carriers.
 * assumes a 32-bit apb register bus with word-aligned registers.
 */
package drsl_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_HW_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PWR_CTL   = 8'h04;
    localparam logic [7:0] ADDR_BYTE_TEST = 8'h08;
    localparam logic [7:0] ADDR_RST_CTL   = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK  = 8'h14;
    localparam logic [7:0] ADDR_STRAPS    = 8'h18;

    // field positions
    localparam int READY_PWR_BIT   = 0;
    localparam int READY_HWCFG_BIT = 27;
    localparam int SLEEP_EN_BIT    = 28;
    localparam int CORE_RST_BIT    = 0;
    localparam int INT_READY_BIT   = 0;
    localparam int INT_WIDTH       = 1;
    localparam int STRAP_WIDTH     = 8;

    // reset values
    localparam logic [31:0]            BYTE_TEST_VAL = 32'h87654321;
    localparam logic [INT_WIDTH-1:0]   INT_RST       = 1'h0;
    localparam logic [STRAP_WIDTH-1:0] STRAP_RST     = 8'h00;

    // sequencing states
    typedef enum logic [3:0] {
        DRSL_ST_LOAD  = 4'h1,
        DRSL_ST_READY = 4'h2,
        DRSL_ST_SLEEP = 4'h4,
        DRSL_ST_WAKE  = 4'h8
    } drsl_state_t;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } drsl_apb_req_t;

    // apb answer carrier
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } drsl_apb_rsp_t;

endpackage

// ==== core/drsl_core.sv ====
/*
 * device-ready status logic: ready flag sequencing over eeprom load, core reload,
 * sleep and wake, ready interrupt, strap latching and its apb register file.
 * assumes the eeprom loader, pll and power controller share mclk_i; the strap
 * pins and wake pin are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps

// Overview of operation
// - a read-only ready flag sits at bit 0 of the power management control register.
// - each rising edge of the ready flag sets the ready interrupt status bit.
// - bit 27 of the hardware config register always reads the same ready value.
// - after any chip-level reset ready rises only once the eeprom load is applied.
// - a core reset from the reset control register reloads eeprom with ready low.
// - entry into any power-saving state drops the ready flag.
// - on wake ready stays low until full power is back and the pll is locked.
// - strap inputs are latched only at power-on, fieldbus or pin reset.
// - the sleep enable bit clears itself on wake-up.
module drsl_core
    import drsl_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   srst_i,
    // apb slave
    input  wire drsl_apb_req_t          apb_req_i,
    output drsl_apb_rsp_t               apb_rsp_o,
    // eeprom loader
    input  wire logic                   load_done_i,
    output logic                        load_start_o,
    // power and pll
    input  wire logic                   wake_pin_i,
    input  wire logic                   pll_lock_i,
    // straps
    input  wire logic [STRAP_WIDTH-1:0] strap_pins_i,
    input  wire logic                   strap_latch_i,
    output logic [STRAP_WIDTH-1:0]      straps_o,
    // status
    output logic                        ready_o,
    output logic                        irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins

    logic [2:0]             wake_sync_q;
    logic [STRAP_WIDTH-1:0] strap_s1_q;
    logic [STRAP_WIDTH-1:0] strap_s2_q;
    logic [STRAP_WIDTH-1:0] strap_s3_q;
    logic                   wake_seen;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wake_sync_q <= 3'h0;
        end else begin
            wake_sync_q <= {wake_sync_q[1:0], wake_pin_i};
        end
    end

    // first stage feeds only the second
    assign wake_seen = wake_sync_q[1] & wake_sync_q[2];

    always_ff @(posedge mclk_i) begin
        strap_s1_q <= strap_pins_i;
        strap_s2_q <= strap_s1_q;
        strap_s3_q <= strap_s2_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // strap latch

    logic [STRAP_WIDTH-1:0] straps_q;
    logic                   latch_arm_q;

    // latch only after reset
    // strap_latch_i marks resets of the power-on, fieldbus or pin kind; digital resets skip it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            latch_arm_q <= strap_latch_i;
        end else if (latch_arm_q && (strap_s2_q == strap_s3_q)) begin
            latch_arm_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (latch_arm_q && !srst_i && (strap_s2_q == strap_s3_q)) begin
            straps_q <= strap_s3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic        acc_q;
    logic        wr_ok;
    logic        rd_ok;
    logic        allowed;
    logic [31:0] rdata_d;
    logic        sleep_en_q;
    logic        core_rst_req;
    logic        sts_rd;
    drsl_state_t state_q;
    logic        ready_q;
    logic [INT_WIDTH-1:0] interrupt_status_register_q;
    logic [INT_WIDTH-1:0] int_mask_q;

    wire setup = apb_req_i.psel & ~apb_req_i.penable;

    assign allowed = ready_q
                   || apb_req_i.paddr == ADDR_HW_CONFIG
                   || apb_req_i.paddr == ADDR_PWR_CTL
                   || apb_req_i.paddr == ADDR_BYTE_TEST
                   || apb_req_i.paddr == ADDR_RST_CTL;

    assign wr_ok = acc_q & apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & ready_q;
    // read side effects at setup, the edge that also takes the read data
    assign rd_ok = setup & ~apb_req_i.pwrite;
    assign core_rst_req = wr_ok && apb_req_i.paddr == ADDR_RST_CTL
                          && apb_req_i.pwdata[CORE_RST_BIT];
    assign sts_rd = rd_ok && allowed && apb_req_i.paddr == ADDR_IRQ_STAT;

    // no wait state: setup, then the first access cycle is answered at its closing edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= setup;
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (allowed) begin
            unique case (apb_req_i.paddr)
                ADDR_HW_CONFIG: rdata_d[READY_HWCFG_BIT] = ready_q;
                // bits 4 to 1 stay zero
                ADDR_PWR_CTL: begin
                    rdata_d[READY_PWR_BIT] = ready_q;
                    rdata_d[SLEEP_EN_BIT]  = sleep_en_q;
                end
                ADDR_BYTE_TEST: rdata_d = BYTE_TEST_VAL;
                ADDR_IRQ_STAT:  rdata_d[INT_WIDTH-1:0] = interrupt_status_register_q;
                ADDR_INT_MASK:  rdata_d[INT_WIDTH-1:0] = int_mask_q;
                ADDR_STRAPS:    rdata_d[STRAP_WIDTH-1:0] = straps_q;
                default:        rdata_d = 32'h00000000;
            endcase
        end
    end

    // answer stands in the access cycle; data is taken at the setup edge,
    // so a status clear and the data it returns can never disagree
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            apb_rsp_o <= '0;
        end else begin
            apb_rsp_o.pready  <= setup;
            apb_rsp_o.pslverr <= 1'b0;
            apb_rsp_o.prdata  <= setup ? rdata_d : 32'h00000000;
            if (acc_q) begin
                apb_rsp_o.pready <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            int_mask_q <= INT_RST;
        end else if (wr_ok && apb_req_i.paddr == ADDR_INT_MASK) begin
            int_mask_q <= apb_req_i.pwdata[INT_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sleep_en_q <= 1'b0;
        end else if (state_q == DRSL_ST_SLEEP && wake_seen) begin
            sleep_en_q <= 1'b0;
        end else if (wr_ok && apb_req_i.paddr == ADDR_PWR_CTL) begin
            sleep_en_q <= apb_req_i.pwdata[SLEEP_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ready sequencing

    logic load_start_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q      <= DRSL_ST_LOAD;
            load_start_q <= 1'b1;
        end else begin
            load_start_q <= 1'b0;
            unique case (state_q)
                DRSL_ST_LOAD: begin
                    if (load_done_i && !load_start_q) begin
                        state_q <= DRSL_ST_READY;
                    end
                end
                DRSL_ST_READY: begin
                    if (core_rst_req) begin
                        state_q      <= DRSL_ST_LOAD;
                        load_start_q <= 1'b1;
                    end else if (sleep_en_q) begin
                        state_q <= DRSL_ST_SLEEP;
                    end
                end
                DRSL_ST_SLEEP: begin
                    if (wake_seen) begin
                        state_q <= DRSL_ST_WAKE;
                    end
                end
                DRSL_ST_WAKE: begin
                    if (pll_lock_i) begin
                        state_q <= DRSL_ST_READY;
                    end
                end
                default: state_q <= DRSL_ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (state_q == DRSL_ST_READY) && !core_rst_req && !sleep_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt

    logic ready_d1_q;
    logic irq_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ready_d1_q <= 1'b0;
        end else begin
            ready_d1_q <= ready_q;
        end
    end

    // rising edge sets status, set beats read clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            interrupt_status_register_q <= INT_RST;
        end else if (ready_q && !ready_d1_q) begin
            interrupt_status_register_q[INT_READY_BIT] <= 1'b1;
        end else if (sts_rd) begin
            interrupt_status_register_q <= INT_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(interrupt_status_register_q & int_mask_q);
        end
    end

    assign straps_o     = straps_q;
    assign ready_o      = ready_q;
    assign irq_o        = irq_q;
    assign load_start_o = load_start_q;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    chk_ready_mirror: assert property (
        (acc_q && !apb_req_i.pwrite && apb_req_i.paddr == ADDR_HW_CONFIG)
        |-> apb_rsp_o.prdata[READY_HWCFG_BIT] == $past(ready_q))
        else $error("hw config ready copy differs");
    chk_ready_bit0: assert property (
        (acc_q && apb_req_i.paddr == ADDR_PWR_CTL)
        |-> apb_rsp_o.prdata[READY_PWR_BIT] == $past(ready_q))
        else $error("power control ready bit wrong");
    chk_rsvd_zero: assert property (
        (acc_q && apb_req_i.paddr == ADDR_PWR_CTL) |-> apb_rsp_o.prdata[4:1] == 4'h0)
        else $error("reserved power control bits not zero");
    chk_irq_mask: assert property (
        (interrupt_status_register_q[INT_READY_BIT] && int_mask_q[INT_READY_BIT]) |=> irq_q)
        else $error("enabled ready event gave no interrupt");
    chk_sleep_drop: assert property (
        sleep_en_q |=> !ready_q)
        else $error("ready high with sleep requested");
    chk_edge_sets: assert property (
        $rose(ready_q) |=> interrupt_status_register_q[INT_READY_BIT])
        else $error("ready edge did not set status");
    chk_write_gated: assert property (
        (acc_q && apb_req_i.pwrite && !ready_q) |=> $stable(int_mask_q))
        else $error("write taken while not ready");
    chk_load_first: assert property (
        (state_q == DRSL_ST_LOAD) |=> !ready_q)
        else $error("ready high during load");
    chk_reload_low: assert property (
        core_rst_req |=> !ready_q ##1 (state_q == DRSL_ST_LOAD))
        else $error("core reset did not drop ready");
    chk_sleep_low: assert property (
        (state_q == DRSL_ST_SLEEP) |=> !ready_q)
        else $error("ready high in sleep");
    chk_wake_pll: assert property (
        (state_q == DRSL_ST_WAKE && !pll_lock_i) |=> !ready_q [*2])
        else $error("ready before pll lock");
    chk_strap_hold: assert property (
        !latch_arm_q |=> $stable(straps_q))
        else $error("straps changed outside reset");
    chk_wake_clear: assert property (
        (state_q == DRSL_ST_SLEEP && wake_seen) |=> !sleep_en_q)
        else $error("sleep enable not cleared on wake");
    chk_reset_zero: assert property (@(posedge mclk_i) disable iff (1'b0)
        srst_i |=> !ready_q)
        else $error("ready not zero after reset");
    chk_read_gate: assert property (
        (acc_q && !apb_req_i.pwrite && !$past(ready_q) && apb_req_i.paddr == ADDR_IRQ_STAT)
        |-> apb_rsp_o.prdata == 32'h0)
        else $error("forbidden read returned data");

    cov_first_ready: cover property ($rose(ready_q));
    cov_reload:      cover property (core_rst_req ##[1:50] $rose(ready_q));
    cov_wake:        cover property (state_q == DRSL_ST_SLEEP ##[1:50] state_q == DRSL_ST_READY);
    cov_irq:         cover property ($rose(irq_q));

endmodule

// ==== test/drsl_host_model.sv ====
/*
 * host model: apb master that reads and writes the ready logic's registers.
 * assumes one clock shared with the design and a registered pready.
 */
`timescale 1ns/1ps

module drsl_host_model
    import drsl_pkg::*;
(
    // clock
    input  wire logic          mclk_i,
    // apb
    input  wire drsl_apb_rsp_t rsp_i,
    output drsl_apb_req_t      req_o,
    // status
    input  wire logic          ready_i
);

    initial req_o = '0;

    ////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        while (!ready_i && (w || !(a inside {ADDR_HW_CONFIG, ADDR_PWR_CTL,
                                                ADDR_BYTE_TEST, ADDR_RST_CTL})))
            @(posedge mclk_i);
        @(posedge mclk_i);
        req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk_i);
        req_o.penable <= 1'b1;
        // held until pready is sampled high
        do @(posedge mclk_i); while (rsp_i.pready !== 1'b1);
        r = rsp_i.prdata;
        req_o <= '0;
    endtask

endmodule

// ==== test/drsl_core_tb.sv ====
/*
 * self-checking bench for the ready logic: loader model, apb host, straps,
 * sleep and wake. assumes a single 250 mhz clock and synchronous reset.
 */
`timescale 1ns/1ps

module drsl_core_tb
    import drsl_pkg::*;
;

    logic                   mclk_i        = 1'b0;
    logic                   srst_i        = 1'b1;
    logic                   load_done_i   = 1'b0;
    logic                   wake_pin_i    = 1'b0;
    logic                   pll_lock_i    = 1'b1;
    logic                   strap_latch_i = 1'b1;
    logic [STRAP_WIDTH-1:0] strap_pins_i  = '0;
    logic [STRAP_WIDTH-1:0] sv;
    logic [STRAP_WIDTH-1:0] straps_o;
    logic                   load_start_o;
    logic                   ready_o;
    logic                   irq_o;
    drsl_apb_req_t          req;
    drsl_apb_rsp_t          rsp;
    logic [4:0]             ld_cnt        = '0;
    logic [31:0]            seed          = 32'd77478;
    logic [31:0]            r;
    logic [31:0]            v;
    int                     num_errors    = 0;
    int                     n_tests       = 0;

    always #2 mclk_i = ~mclk_i;

    drsl_core uut (.mclk_i, .srst_i, .apb_req_i(req), .apb_rsp_o(rsp), .load_done_i,
                   .load_start_o, .wake_pin_i, .pll_lock_i, .strap_pins_i,
                   .strap_latch_i, .straps_o, .ready_o, .irq_o);

    drsl_host_model host (.mclk_i, .rsp_i(rsp), .req_o(req), .ready_i(ready_o));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // eeprom loader: random 8 to 15 cycles, so timing of ready varies
    always @(posedge mclk_i) begin
        if (load_start_o) begin
            ld_cnt      <= 5'h08 + 5'(nxt() & 32'h7);
            load_done_i <= 1'b0;
        end else if (ld_cnt != 5'h00) begin
            ld_cnt      <= ld_cnt - 5'h01;
            load_done_i <= (ld_cnt == 5'h01);
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy(input logic want);
        int i;
        i = 0;
        while (ready_o !== want && i < 300) begin
            @(posedge mclk_i);
            i++;
        end
        chk({31'h0, ready_o}, {31'h0, want});
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, r);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        host.xfer(1'b1, a, d, dummy);
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sv = 8'(nxt());
        strap_pins_i = sv;
        repeat (10) @(posedge mclk_i);
        chk({31'h0, ready_o}, 32'h0);
        srst_i        <= 1'b0;
        strap_latch_i <= 1'b0;
        rd(ADDR_PWR_CTL);
        chk(r & 32'h1f, 32'h0);
        rd(ADDR_HW_CONFIG);
        chk({31'h0, r[READY_HWCFG_BIT]}, 32'h0);
        rd(ADDR_BYTE_TEST);
        chk(r, BYTE_TEST_VAL);
        wait_rdy(1'b1);
        strap_pins_i <= ~sv;
        rd(ADDR_PWR_CTL);
        chk(r & 32'h1f, 32'h1);
        rd(ADDR_HW_CONFIG);
        chk({31'h0, r[READY_HWCFG_BIT]}, 32'h1);
        rd(ADDR_IRQ_STAT);
        chk(r & 32'h1, 32'h1);
        rd(ADDR_IRQ_STAT);
        chk(r & 32'h1, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        rd(ADDR_STRAPS);
        chk(r & 32'hff, {24'h0, sv});
        rd(8'h1c);
        chk(r, 32'h0);
        // ready is read-only: a zero write must not clear it
        wr(ADDR_PWR_CTL, 32'h0);
        rd(ADDR_PWR_CTL);
        chk(r & 32'h1f, 32'h1);
        wr(ADDR_BYTE_TEST, nxt());
        rd(ADDR_BYTE_TEST);
        chk(r, BYTE_TEST_VAL);
        for (int k = 0; k < 4; k++) begin
            v = nxt();
            wr(ADDR_INT_MASK, v);
            rd(ADDR_INT_MASK);
            chk(r & 32'h1, v & 32'h1);
        end
        wr(ADDR_INT_MASK, 32'h1);
        wr(ADDR_RST_CTL, 32'h1 << CORE_RST_BIT);
        wait_rdy(1'b0);
        wait_rdy(1'b1);
        repeat (3) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h1);
        rd(ADDR_IRQ_STAT);
        repeat (3) @(posedge mclk_i);
        chk({31'h0, irq_o}, 32'h0);
        chk({24'h0, straps_o}, {24'h0, sv});
        wr(ADDR_PWR_CTL, 32'h1 << SLEEP_EN_BIT);
        wait_rdy(1'b0);
        pll_lock_i <= 1'b0;
        wake_pin_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        chk({31'h0, ready_o}, 32'h0);
        pll_lock_i <= 1'b1;
        wait_rdy(1'b1);
        wake_pin_i <= 1'b0;
        rd(ADDR_PWR_CTL);
        chk(r & 32'h1000_001f, 32'h1);
        // digital reset without strap latch
        srst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({31'h0, ready_o}, 32'h0);
        srst_i <= 1'b0;
        wait_rdy(1'b1);
        chk({24'h0, straps_o}, {24'h0, sv});
        final_report;
    end

endmodule
